// ===== verilog/lcdh_pkg.sv
/*
  Constants and types shared by the LCD host serial port.
  Assumes every user of it imports the whole package.
*/
`default_nettype none

package lcdh_pkg;

  // Positions in the synchroniser vector
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_CSN = 2;
  localparam int SY_CSP = 3;
  localparam int SY_A0  = 4;
  localparam int SY_SAL = 5;
  localparam int SY_SAH = 6;
  localparam int SY_BMU = 7;
  localparam int SY_BML = 8;
  localparam int SY_W   = 9;

  // Word and pointer widths
  localparam int BYTE_W = 8;
  localparam int COL_W  = 8;
  localparam int STAT_W = 16;

  // Values after reset
  localparam logic [COL_W-1:0]  COL_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] WORD_RST = 8'h00;

  // Bit counts
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] RD_LAST  = 4'hF;

  // Opcodes seen by the port itself
  localparam logic [7:0] STATUS_CMD = 8'hFE;
  localparam logic [3:0] COL_LO_OP  = 4'h0;
  localparam logic [3:0] COL_HI_OP  = 4'h1;

  // Fixed upper part of the two-wire slave address
  localparam logic [3:0] ADDR_PREFIX = 4'h7;

  // Two-wire link phases
  typedef enum logic [7:0] {
    PH_IDLE  = 8'h01,
    PH_ADDR  = 8'h02,
    PH_ACKD  = 8'h04,
    PH_ACKH  = 8'h08,
    PH_RX    = 8'h10,
    PH_TX    = 8'h20,
    PH_TXACK = 8'h40,
    PH_IGN   = 8'h80
  } lcdh_phase_e;

endpackage

`default_nettype wire

// ===== verilog/lcdh_sync.sv
/*
  Two-flop synchroniser for a vector of unrelated pin levels.
  Assumes each bit is a slow level or a clock far below the sampling rate.
*/
`timescale 1ns/10ps
`default_nettype none

module lcdh_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } lcdh_sync_s;

  lcdh_sync_s st_ff;
  lcdh_sync_s nxt_st;

  // First stage feeds only the second
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = d;
    nxt_st.safe = st_ff.meta;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.safe;

endmodule

`default_nettype wire

// ===== verilog/lcdh_host_port.sv
/*
  Serial host front end of a graphic LCD controller: 4-line shift link and
  two-wire slave link, both clocked by the host on scl.
  Assumes all pins are asynchronous to clock and scl is far slower than it;
  the board resolves the open-drain data wire from sda_oe.
*/
// Behaviour
// - 4-line link takes data and clock only with chip_select_n low, chip_select_p high.
// - Deselecting the 4-line link clears shift register and bit counter.
// - 4-line byte is display data when cmd_data_select high, else instruction.
// - 4-line data sampled on each rising serial clock outside a status read, MSB first.
// - Eighth serial clock hands the assembled byte on as one parallel word.
// - Column pointer steps by one after every display RAM byte.
// - Status bytes can be read back over the 4-line link.
// - Two-wire transmitters change data only while clock is low.
// - Data falling with clock high is START; rising with clock high is STOP.
// - Addressed receiver holds data low through the ninth clock high phase.
// - Missing master acknowledge stops sending and leaves data released.
// - Slave address is fixed prefix, two strap bits, command/data flag, then read/write bit.
// - Address bits 3 and 2 come from the address strap pins.
// - Foreign address is not acknowledged; rest ignored until next START.
// - Command/data flag of the address byte steers the following bytes.
// - Flag one writes bytes to display RAM and steps the pointer.
// - Flag zero sends bytes to the command decoder.
// - Every byte received by an addressed slave is acknowledged.
// - Two-wire link accepts command and display data writes.
// - Both mode straps low select 4-line; both high select two-wire.
// - chip_select_n is chip select in 4-line, address strap in two-wire.
`timescale 1ns/10ps
`default_nettype none

module lcdh_host_port
  import lcdh_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              bus_mode_strap_upper,
  input  wire logic              bus_mode_strap_lower,
  input  wire logic              chip_select_n,
  input  wire logic              chip_select_p,
  input  wire logic              cmd_data_select,
  input  wire logic              addr_strap_low,
  input  wire logic              addr_strap_high,
  input  wire logic              scl,
  input  wire logic              sda_in,
  input  wire logic [STAT_W-1:0] status_word,
  output logic                   sda_out,
  output logic                   sda_oe,
  output logic                   word_valid,
  output logic      [BYTE_W-1:0] word_data,
  output logic                   word_is_data,
  output logic      [COL_W-1:0]  col_addr
);

  typedef struct packed {
    lcdh_phase_e       ph;
    logic              scl_q;
    logic              sda_q;
    logic [BYTE_W-1:0] shift;
    logic [2:0]        cnt;
    logic              ad;
    logic              rd;
    logic              half;
    logic              srd;
    logic [3:0]        rd_cnt;
    logic [STAT_W-1:0] tx;
    logic              sdo;
    logic              oe;
    logic              wv;
    logic [BYTE_W-1:0] word;
    logic              isd;
    logic [COL_W-1:0]  col;
  } lcdh_state_s;

  lcdh_state_s st_ff;
  lcdh_state_s nxt_st;
  logic [SY_W-1:0] sy;

  // Every pin level passes two flops before use
  lcdh_sync #(
    .W (SY_W)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      ({bus_mode_strap_lower, bus_mode_strap_upper, addr_strap_high,
              addr_strap_low, cmd_data_select, chip_select_p, chip_select_n,
              sda_in, scl}),
    .q      (sy)
  );

  logic scl_s;
  logic sda_s;
  logic a0_s;
  logic mode_spi;
  logic mode_i2c;
  logic spi_act;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic own_addr;

  // Decoded link conditions
  always_comb begin
    scl_s    = sy[SY_SCL];
    sda_s    = sy[SY_SDA];
    a0_s     = sy[SY_A0];
    mode_spi = !sy[SY_BMU] && !sy[SY_BML];
    mode_i2c = sy[SY_BMU] && sy[SY_BML];
    spi_act  = !sy[SY_CSN] && sy[SY_CSP];
    scl_rise = scl_s && !st_ff.scl_q;
    scl_fall = !scl_s && st_ff.scl_q;
    start_c  = scl_s && st_ff.scl_q && st_ff.sda_q && !sda_s;
    stop_c   = scl_s && st_ff.scl_q && !st_ff.sda_q && sda_s;
  end

  logic              dv;
  logic [BYTE_W-1:0] db;
  logic              disd;
  logic [BYTE_W-1:0] rx_byte;
  logic [STAT_W-1:0] src;

  // Next state of both links
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_q = scl_s;
    nxt_st.sda_q = sda_s;
    nxt_st.wv    = 1'b0;
    dv           = 1'b0;
    db           = WORD_RST;
    disd         = 1'b0;
    rx_byte      = {st_ff.shift[6:0], sda_s};
    src          = st_ff.half ? st_ff.tx : status_word;
    // Pin doubles as low strap; board ties addr_strap_low high to use it
    own_addr     = rx_byte[7:4] == ADDR_PREFIX
                   && rx_byte[3] == sy[SY_SAH]
                   && rx_byte[2] == (sy[SY_SAL] && sy[SY_CSN]);
    if (mode_spi) begin
      nxt_st.ph = PH_IDLE;
      if (!spi_act) begin
        // Half-received byte is thrown away
        nxt_st.shift  = WORD_RST;
        nxt_st.cnt    = '0;
        nxt_st.srd    = 1'b0;
        nxt_st.rd_cnt = '0;
      end else if (scl_rise) begin
        if (st_ff.srd) begin
          nxt_st.rd_cnt = st_ff.rd_cnt + 4'h1;
          if (st_ff.rd_cnt == RD_LAST) begin
            nxt_st.srd = 1'b0;
          end
        end else begin
          nxt_st.shift = rx_byte;
          nxt_st.cnt   = st_ff.cnt + 3'h1;
          if (st_ff.cnt == BIT_LAST) begin
            dv   = 1'b1;
            db   = rx_byte;
            disd = a0_s;
            if (!a0_s && rx_byte == STATUS_CMD) begin
              nxt_st.srd    = 1'b1;
              nxt_st.tx     = status_word;
              nxt_st.rd_cnt = '0;
            end
          end
        end
      end else if (scl_fall && st_ff.srd) begin
        // Status bits leave on the falling edge, host samples on rising
        nxt_st.oe  = 1'b1;
        nxt_st.sdo = st_ff.tx[STAT_W-1];
        nxt_st.tx  = {st_ff.tx[STAT_W-2:0], 1'b0};
      end
      if (!nxt_st.srd) begin
        nxt_st.oe  = 1'b0;
        nxt_st.sdo = 1'b0;
      end
    end else if (mode_i2c) begin
      nxt_st.srd = 1'b0;
      nxt_st.sdo = 1'b0;
      if (start_c) begin
        nxt_st.ph  = PH_ADDR;
        nxt_st.cnt = '0;
        nxt_st.half = 1'b0;
        nxt_st.oe  = 1'b0;
      end else if (stop_c) begin
        nxt_st.ph = PH_IDLE;
        nxt_st.oe = 1'b0;
      end else begin
        case (st_ff.ph)
          PH_ADDR, PH_RX: begin
            if (scl_rise) begin
              nxt_st.shift = rx_byte;
              nxt_st.cnt   = st_ff.cnt + 3'h1;
              if (st_ff.cnt == BIT_LAST) begin
                if (st_ff.ph == PH_RX) begin
                  dv        = 1'b1;
                  db        = rx_byte;
                  disd      = st_ff.ad;
                  nxt_st.ph = PH_ACKD;
                end else if (own_addr) begin
                  nxt_st.ad = rx_byte[1];
                  nxt_st.rd = rx_byte[0];
                  nxt_st.ph = PH_ACKD;
                end else begin
                  nxt_st.ph = PH_IGN;
                end
              end
            end
          end
          PH_ACKD: begin
            // Pull low only once the clock is low again
            if (scl_fall) begin
              nxt_st.oe = 1'b1;
              nxt_st.ph = PH_ACKH;
            end
          end
          PH_ACKH, PH_TXACK: begin
            if (st_ff.ph == PH_TXACK && scl_rise && sda_s) begin
              // High at the ninth rise means no acknowledge: stop, stay released
              nxt_st.ph = PH_IGN;
              nxt_st.rd = 1'b0;
            end else if (scl_fall) begin
              nxt_st.cnt = '0;
              if (st_ff.rd) begin
                // Low half continues from tx, high half reloads status
                nxt_st.oe   = !src[STAT_W-1];
                nxt_st.tx   = {src[STAT_W-2:0], 1'b0};
                nxt_st.cnt  = 3'h1;
                nxt_st.ph   = PH_TX;
              end else begin
                nxt_st.oe = 1'b0;
                nxt_st.ph = PH_RX;
              end
            end
          end
          PH_TX: begin
            if (scl_fall) begin
              if (st_ff.cnt == 3'h0) begin
                nxt_st.oe   = 1'b0;
                nxt_st.half = !st_ff.half;
                nxt_st.ph   = PH_TXACK;
              end else begin
                nxt_st.oe  = !st_ff.tx[STAT_W-1];
                nxt_st.tx  = {st_ff.tx[STAT_W-2:0], 1'b0};
                nxt_st.cnt = st_ff.cnt + 3'h1;
              end
            end
          end
          default: begin
            nxt_st.oe = 1'b0;
          end
        endcase
      end
    end else begin
      // Mixed straps: link parked
      nxt_st.ph  = PH_IDLE;
      nxt_st.oe  = 1'b0;
      nxt_st.sdo = 1'b0;
      nxt_st.srd = 1'b0;
    end
    // Word hand-off and column pointer
    if (dv) begin
      nxt_st.wv   = 1'b1;
      nxt_st.word = db;
      nxt_st.isd  = disd;
      if (disd) begin
        nxt_st.col = st_ff.col + 8'h01;
      end else if (db[7:4] == COL_LO_OP) begin
        nxt_st.col[3:0] = db[3:0];
      end else if (db[7:4] == COL_HI_OP) begin
        nxt_st.col[7:4] = db[3:0];
      end
    end
  end

  // Single state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff     <= '0;
      st_ff.ph  <= PH_IDLE;
      st_ff.col <= COL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign sda_out      = st_ff.sdo;
  assign sda_oe       = st_ff.oe;
  assign word_valid   = st_ff.wv;
  assign word_data    = st_ff.word;
  assign word_is_data = st_ff.isd;
  assign col_addr     = st_ff.col;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_spi_desel_clear: assert property (
    mode_spi && !spi_act |=> st_ff.cnt == 3'h0 && st_ff.shift == 8'h00)
    else $error("4-line shifter not cleared on deselect");

  a_spi_only_sel: assert property (
    st_ff.wv && $past(mode_spi) |-> $past(spi_act) && $past(scl_rise))
    else $error("4-line word taken while deselected");

  a_spi_kind: assert property (
    st_ff.wv && $past(mode_spi) |-> st_ff.isd == $past(a0_s))
    else $error("4-line word kind does not follow select pin");

  a_word_pulse: assert property (
    st_ff.wv |=> !st_ff.wv [*2])
    else $error("word strobe longer than one cycle");

  a_col_step: assert property (
    nxt_st.wv && nxt_st.isd |=> st_ff.col == $past(st_ff.col) + 8'h01)
    else $error("column pointer did not step by one");

  a_ack_hold: assert property (
    st_ff.ph == PH_ACKH && scl_s |-> st_ff.oe && !st_ff.sdo)
    else $error("acknowledge not held through clock high");

  a_no_high: assert property (
    mode_i2c && $past(mode_i2c) |-> !st_ff.sdo)
    else $error("two-wire data driven high");

  a_nack_release: assert property (
    mode_i2c && st_ff.ph == PH_TXACK && scl_rise && sda_s && !stop_c
    |=> st_ff.ph == PH_IGN && !st_ff.oe)
    else $error("transmit not stopped after missing acknowledge");

  a_start_addr: assert property (
    mode_i2c && start_c |=> st_ff.ph == PH_ADDR && st_ff.cnt == 3'h0)
    else $error("START not followed by address phase");

  a_stop_idle: assert property (
    mode_i2c && stop_c && !start_c |=> st_ff.ph == PH_IDLE && !st_ff.oe)
    else $error("STOP not returning to idle");

  a_ign_quiet: assert property (
    st_ff.ph == PH_IGN |-> !st_ff.oe && !st_ff.wv)
    else $error("ignored transfer still answered");

  a_scl_low_change: assert property (
    mode_i2c && $past(mode_i2c) && $changed(st_ff.oe) && st_ff.ph != PH_IDLE
    && st_ff.ph != PH_ADDR |-> !$past(scl_s))
    else $error("data line changed while clock high");

endmodule

`default_nettype wire

// ===== verification/lcdh_host_model.sv
/*
  Host controller model driving the 4-line and two-wire links.
  Assumes the bench resolves the wired data line into sda_line.
*/
`timescale 1ns/10ps
`default_nettype none

module lcdh_host_model (
  input  wire logic clock,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv,
  output logic      csn,
  output logic      csp,
  output logic      a0
);
  // Idle bus: clock parked high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    csn = 1'b1;
    csp = 1'b0;
    a0 = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Data moves mid-low so it never changes with scl high
  task automatic bit_out(input logic b);
    scl <= 1'b0;
    q(2);
    sda_drv <= b;
    q(2);
    scl <= 1'b1;
    q(4);
  endtask

  task automatic pins(input logic n, input logic p);
    csn <= n;
    csp <= p;
    q(8);
  endtask

  // First n bits of b, MSB first; stale data line inverted afterwards
  task automatic spi_bits(input logic [7:0] b, input int n, input logic cd, input logic sn,
                          input logic sp);
    csn <= sn;
    csp <= sp;
    a0 <= cd;
    for (int i = 7; i > 7 - n; i--) bit_out(b[i]);
    sda_drv <= ~b[8-n];
  endtask

  task automatic spi_read16(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      scl <= 1'b0;
      q(2);
      sda_drv <= 1'b1;
      q(2);
      scl <= 1'b1;
      q(2);
      w[i] = sda_line;
      q(2);
    end
  endtask

  // Start only from an idle bus
  task automatic i2c_start();
    q(8);
    sda_drv <= 1'b0;
    q(4);
  endtask

  task automatic i2c_stop();
    scl <= 1'b0;
    q(2);
    sda_drv <= 1'b0;
    q(2);
    scl <= 1'b1;
    q(4);
    sda_drv <= 1'b1;
    q(8);
  endtask

  // Acknowledge is sampled once, at the end of the ninth clock high phase
  task automatic i2c_write(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_out(1'b1);
    nak = sda_line;
    q(2);
  endtask

  // Master acknowledge or withholds it on the last byte
  task automatic i2c_read(input logic nak_in, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      q(2);
      sda_drv <= 1'b1;
      q(2);
      scl <= 1'b1;
      q(2);
      b[i] = sda_line;
      q(2);
    end
    bit_out(nak_in);
  endtask
endmodule

`default_nettype wire

// ===== verification/tb.sv
/*
  Self-checking bench for the LCD host serial port.
  Assumes lcdh_host_model as the host and a pull-up on the data wire.
*/
`timescale 1ns/10ps
`default_nettype none

module tb
  import lcdh_pkg::*;
();
  logic              clock = 1'b0;
  logic              resetn;
  logic              strap;
  logic              strap_l;
  logic              sal;
  logic              sah;
  logic [STAT_W-1:0] status;
  logic              scl;
  logic              sda_drv;
  logic              csn;
  logic              csp;
  logic              a0;
  logic              sda_out;
  logic              sda_oe;
  logic              word_valid;
  logic              word_is_data;
  logic [BYTE_W-1:0] word_data;
  logic [COL_W-1:0]  col_addr;
  logic [15:0]       rd;
  logic              nak;
  int                failures = 0;
  int                num_checks = 0;
  logic [16:0]       words[$];

  // Wired data line: either side only pulls low against the pull-up
  wire logic sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  always #4 clock = ~clock;

  lcdh_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
    .csn(csn), .csp(csp), .a0(a0));

  lcdh_host_port dut (.clock(clock), .resetn(resetn), .bus_mode_strap_upper(strap),
    .bus_mode_strap_lower(strap_l), .chip_select_n(csn), .chip_select_p(csp),
    .cmd_data_select(a0), .addr_strap_low(sal), .addr_strap_high(sah), .scl(scl),
    .sda_in(sda_line), .status_word(status), .sda_out(sda_out), .sda_oe(sda_oe),
    .word_valid(word_valid), .word_data(word_data), .word_is_data(word_is_data),
    .col_addr(col_addr));

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Collect presented bytes; two-wire drive must only ever be low
  always @(posedge clock) begin
    if (word_valid === 1'b1) words.push_back({word_is_data, word_data, col_addr});
    if (strap === 1'b1 && sda_oe === 1'b1) check("low drive", sda_out, 17'h0);
  end

  task automatic expect_word(input logic d, input logic [7:0] b, input logic [7:0] col);
    logic [16:0] w;
    w = 'x;
    if (words.size() > 0) w = words.pop_front();
    check("word", w, {d, b, col});
  endtask

  task automatic sb(input logic [7:0] b, input logic cd);
    host.spi_bits(b, 8, cd, 1'b0, 1'b1);
  endtask

  task automatic t_spi_write();
    sb(8'hA5, 1'b1);
    sb(8'h3C, 1'b1);
    sb(8'h05, 1'b0);
    sb(8'h12, 1'b0);
    sb(8'h7E, 1'b1);
    host.q(6);
    expect_word(1'b1, 8'hA5, 8'h01);
    expect_word(1'b1, 8'h3C, 8'h02);
    expect_word(1'b0, 8'h05, 8'h05);
    expect_word(1'b0, 8'h12, 8'h25);
    expect_word(1'b1, 8'h7E, 8'h26);
  endtask

  // Partial byte dropped on deselect; clocks while deselected ignored
  task automatic t_spi_select();
    host.spi_bits(8'hF0, 4, 1'b1, 1'b0, 1'b1);
    host.pins(1'b1, 1'b1);
    sb(8'h81, 1'b1);
    host.spi_bits(8'hAA, 8, 1'b1, 1'b1, 1'b1);
    host.spi_bits(8'h55, 8, 1'b1, 1'b0, 1'b0);
    host.pins(1'b1, 1'b1);
    sb(8'h42, 1'b1);
    host.q(6);
    expect_word(1'b1, 8'h81, 8'h27);
    expect_word(1'b1, 8'h42, 8'h28);
    check("stray words", 17'(words.size()), 17'h0);
  endtask

  task automatic t_spi_status();
    status <= 16'hC3A5;
    sb(8'hFE, 1'b0);
    host.spi_read16(rd);
    check("status read", rd, 17'hC3A5);
    expect_word(1'b0, 8'hFE, 8'h28);
  endtask

  // Mixed straps: neither link may answer or present a word
  task automatic t_mixed();
    sb(8'h66, 1'b1);
    host.i2c_start();
    host.i2c_write(8'h7A, nak);
    check("parked ack", nak, 17'h1);
    host.i2c_stop();
    check("parked words", 17'(words.size()), 17'h0);
  endtask

  // Bit 2 of the address is addr_strap_low gated by chip_select_n
  task automatic t_i2c_write();
    host.pins(1'b0, 1'b1);
    host.i2c_start();
    host.i2c_write(8'h7A, nak);
    check("addr ack", nak, 17'h0);
    host.i2c_write(8'h5A, nak);
    check("data ack", nak, 17'h0);
    host.i2c_write(8'hC3, nak);
    check("data ack", nak, 17'h0);
    host.i2c_stop();
    host.i2c_start();
    host.i2c_write(8'h78, nak);
    check("addr ack", nak, 17'h0);
    host.i2c_write(8'h03, nak);
    check("ctrl ack", nak, 17'h0);
    host.i2c_stop();
    expect_word(1'b1, 8'h5A, 8'h29);
    expect_word(1'b1, 8'hC3, 8'h2A);
    expect_word(1'b0, 8'h03, 8'h23);
  endtask

  task automatic t_i2c_foreign();
    host.pins(1'b1, 1'b1);
    host.i2c_start();
    host.i2c_write(8'h78, nak);
    check("foreign addr", nak, 17'h1);
    host.i2c_write(8'h5A, nak);
    check("ignored byte", nak, 17'h1);
    host.i2c_stop();
    check("no words", 17'(words.size()), 17'h0);
    host.i2c_start();
    host.i2c_write(8'h7C, nak);
    check("strap addr", nak, 17'h0);
    host.i2c_stop();
  endtask

  // Master ack keeps data coming; withheld ack leaves the line released
  task automatic t_i2c_read();
    status <= 16'h5AC3;
    host.pins(1'b0, 1'b1);
    host.i2c_start();
    host.i2c_write(8'h79, nak);
    check("read addr ack", nak, 17'h0);
    host.i2c_read(1'b0, rd[15:8]);
    host.i2c_read(1'b1, rd[7:0]);
    check("read bytes", rd, 17'h5AC3);
    repeat (16) begin
      @(posedge clock);
      check("released", sda_oe, 17'h0);
    end
    host.i2c_stop();
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset, then 4-line scenarios, then mixed straps, then two-wire with both straps high
  initial begin
    resetn = 1'b0;
    strap = 1'b0;
    strap_l = 1'b0;
    sal = 1'b1;
    sah = 1'b1;
    status = 16'h0000;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    host.q(4);
    t_spi_write();
    t_spi_select();
    t_spi_status();
    strap <= 1'b1;
    host.q(8);
    t_mixed();
    strap_l <= 1'b1;
    host.q(8);
    t_i2c_write();
    t_i2c_foreign();
    t_i2c_read();
    summarize();
  end

  // Whole run is a few thousand cycles; this is ample margin
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule

`default_nettype wire
